/* File: hdl/stpg_pkg.sv */
// Constants and types for the serial link test pattern generator
package stpg_pkg;
  localparam int NUM_LANES = 16;
  localparam int LANES_PER_LINK = 8;
  localparam int OCT_W = 8;
  localparam int LFSR_W = 31;
  localparam int FIFO_DEPTH = 4;
  // Clock cycles per serial octet slot
  localparam logic [3:0] SLOT_DIV = 4'h2;
  // Feedback taps: bit n is the XOR of bits n-A and n-B
  localparam int P7_A = 6;
  localparam int P7_B = 7;
  localparam int P9_A = 5;
  localparam int P9_B = 9;
  localparam int P15_A = 14;
  localparam int P15_B = 15;
  localparam int P23_A = 18;
  localparam int P23_B = 23;
  localparam int P31_A = 28;
  localparam int P31_B = 31;
  localparam logic [7:0] SEED_MUL = 8'h25;
  localparam logic [7:0] SEED_ADD = 8'h01;
  localparam logic [7:0] CLK_ONES = 8'hff;
  localparam logic [7:0] CLK_ZEROS = 8'h00;
  localparam logic [7:0] CHAR_D21_5 = 8'hb5;
  localparam logic [7:0] CHAR_K28_5 = 8'hbc;
  localparam logic [7:0] SHORT_TOP = 8'hff;
  localparam logic [3:0] NIB_TOP = 4'hf;
  localparam logic [3:0] NIB_TAIL = 4'h0;
  localparam logic [3:0] NIB_LAST = 4'hf;
  localparam logic [2:0] F_LAST_W8 = 3'h0;
  localparam logic [2:0] F_LAST_F8 = 3'h7;
  localparam logic [2:0] F_LAST_F2 = 3'h1;
  localparam logic [3:0] RPAT_LAST = 4'hb;
  localparam logic [11:0][7:0] RPAT_TBL = {8'h59, 8'h35, 8'hfb, 8'h5e, 8'h14, 8'hb3,
                                           8'h8f, 8'h6b, 8'h47, 8'h23, 8'hd7, 8'hbe};
  typedef enum logic [3:0] {
    STPG_NORMAL = 4'h0, STPG_PRBS7 = 4'h1, STPG_PRBS9 = 4'h2, STPG_PRBS15 = 4'h3,
    STPG_PRBS23 = 4'h4, STPG_PRBS31 = 4'h5, STPG_CLOCK = 4'h6, STPG_RAMP = 4'h7,
    STPG_SHORT = 4'h8, STPG_D21_5 = 4'h9, STPG_K28_5 = 4'ha, STPG_RILA = 4'hb,
    STPG_RPAT = 4'hc
  } stpg_mode_t;
  typedef enum logic [1:0] {
    STPG_W8 = 2'h0, STPG_W12_F8 = 2'h1, STPG_W12_F2S8 = 2'h2, STPG_W12_F2S4 = 2'h3
  } stpg_wmode_t;
  typedef enum logic [1:0] {
    GS_IDLE = 2'b00, GS_WAIT = 2'b01, GS_RUN = 2'b11, GS_CGS = 2'b10
  } stpg_gen_t;
  // One slot of all lanes as it travels through the buffer
  typedef struct packed {
    logic raw;
    logic ila;
    logic [NUM_LANES-1:0] k;
    logic [NUM_LANES-1:0][OCT_W-1:0] data;
  } stpg_lanes_t;
endpackage

/* File: hdl/stpg_top.sv */
// Serial link test pattern generator with its output buffer
//
// Overview of operation
// - PRBS modes bypass transport, scrambler and encoder
// - PRBS7 taps six and seven, period 127
// - PRBS9 taps five and nine, period 511
// - PRBS15 taps fourteen and fifteen
// - PRBS23 taps eighteen and twenty-three
// - PRBS31 taps twenty-eight and thirty-one
// - Every lane seeds its PRBS differently
// - Clock mode sends raw eight ones, eight zeros
// - Ramp keeps link layer, drops transport
// - Ramp starts after ILA or serializer init
// - Ramp identical on all lanes, link-encoded
// - Ramp counts octets, wraps, restarts each multiframe
// - Short pattern for 8/12-bit word modes
// - 8-bit: octet i then 0xFF minus i
// - 12-bit F8: nibbles 0xF-k, k, word index plus one
// - 12-bit F2: nibble count across lanes
// - Only enabled low lanes carry the pattern
// - D21.5 stream under either coding
// - K28.5 stream, 8b/10b only
// - Repeated ILA: sync request, CGS, then ILA
// - RPAT first six octets BE..8F
// - RPAT last six octets B3..59, repeat
// - Lane count follows configured link mode
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// Small synchronous FIFO, valid/ready on both sides
module stpg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } stpg_fifo_st_t;

  stpg_fifo_st_t r;
  stpg_fifo_st_t r_nxt;
  logic push;
  logic pop;

  // Flags straight from the count, so full and empty never lie
  assign in_ready = (r.cnt != FULL);
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    r_nxt = r;
    if (push) begin
      r_nxt.mem[r.wp] = in_data;
      r_nxt.wp = (r.wp == LAST) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      r_nxt.rp = (r.rp == LAST) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      r_nxt.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      r_nxt.cnt = r.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////
// Pattern generator for all sixteen lanes of both links
module stpg_top
  import stpg_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] test_pattern_select,
  input wire logic [1:0] link_word_mode,
  input wire logic [3:0] link_lanes_per_link,
  input wire logic link_64b66b,
  input wire logic [10:0] mf_octets,
  input wire logic ila_done,
  input wire logic serdes_ready,
  input wire logic sync_req_n,
  input wire logic out_ready,
  output logic out_valid,
  output logic [NUM_LANES-1:0][OCT_W-1:0] lane_data,
  output logic [NUM_LANES-1:0] lane_k,
  output logic lane_raw,
  output logic ila_repeat,
  output logic [NUM_LANES-1:0] lane_en,
  output logic mode_unsupported
);
  typedef struct packed {
    logic [1:0] sync;
    logic [3:0] div;
    stpg_mode_t mode;
    stpg_gen_t st;
    logic [NUM_LANES-1:0][LFSR_W-1:0] lfsr;
    logic clk_ph;
    logic [10:0] pos;
    logic [2:0] oct;
    logic frm;
    logic [3:0] rpat;
    logic push;
    stpg_lanes_t pw;
    logic out_valid;
    stpg_lanes_t out;
    logic [NUM_LANES-1:0] en;
    logic bad;
  } stpg_st_t;

  stpg_st_t r;
  stpg_st_t r_nxt;
  logic f_in_ready;
  logic f_out_valid;
  logic f_pop;
  stpg_lanes_t f_out;

  // Distinct nonzero start state per lane; odd multiplier keeps them apart
  function automatic logic [LFSR_W-1:0] lane_seed(input logic [3:0] l);
    logic [7:0] s;
    s = 8'({4'h0, l} * SEED_MUL) + SEED_ADD;
    return {23'h0, s};
  endfunction

  // Eight steps of the selected recursion; newest bit lands in bit 0
  function automatic logic [LFSR_W-1:0] prbs_adv(input logic [LFSR_W-1:0] s, input stpg_mode_t m);
    logic [LFSR_W-1:0] t;
    logic b;
    t = s;
    for (int j = 0; j < OCT_W; j++) begin
      case (m)
        STPG_PRBS7: b = t[P7_A-1] ^ t[P7_B-1];
        STPG_PRBS9: b = t[P9_A-1] ^ t[P9_B-1];
        STPG_PRBS15: b = t[P15_A-1] ^ t[P15_B-1];
        STPG_PRBS23: b = t[P23_A-1] ^ t[P23_B-1];
        STPG_PRBS31: b = t[P31_A-1] ^ t[P31_B-1];
        default: b = 1'b0;
      endcase
      t = {t[LFSR_W-2:0], b};
    end
    return t;
  endfunction

  // Nibble n of the 12-bit eight-octet frame for lane k
  function automatic logic [3:0] nib_f8(input logic [2:0] k, input logic [3:0] n);
    logic [3:0] w;
    logic [1:0] p;
    w = 4'(n / 4'h3);
    p = 2'(n % 4'h3);
    if (n == NIB_LAST) begin
      return NIB_TAIL;
    end
    case (p)
      2'h0: return NIB_TOP - {1'b0, k};
      2'h1: return {1'b0, k};
      default: return w + 4'h1;
    endcase
  endfunction

  // Short transport octet for lane i of a link
  function automatic logic [7:0] short_oct(input logic [1:0] wm, input logic [2:0] i,
                                           input logic [2:0] o, input logic f);
    case (wm)
      STPG_W8: return f ? SHORT_TOP - {5'h0, i} : {5'h0, i};
      STPG_W12_F8: return {nib_f8(i, {o, 1'b0}), nib_f8(i, {o, 1'b1})};
      // Nibble index 4i+2o+x modulo 16, so six-lane links wrap to 0
      default: return {i[1:0], o[0], 1'b0, i[1:0], o[0], 1'b1};
    endcase
  endfunction

  // Last octet index of a frame for the word mode
  function automatic logic [2:0] frame_last(input logic [1:0] wm);
    case (wm)
      STPG_W8: return F_LAST_W8;
      STPG_W12_F8: return F_LAST_F8;
      default: return F_LAST_F2;
    endcase
  endfunction

  stpg_fifo #(
    .WIDTH($bits(stpg_lanes_t)),
    .DEPTH(FIFO_DEPTH)
  ) i_stpg_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(r.push),
    .in_ready(f_in_ready),
    .in_data(r.pw),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out)
  );

  // Output stage takes a word when empty or when the sink accepts
  assign f_pop = !r.out_valid || out_ready;

  // Every top output comes from the state register
  assign out_valid = r.out_valid;
  assign lane_data = r.out.data;
  assign lane_k = r.out.k;
  assign lane_raw = r.out.raw;
  assign ila_repeat = r.out.ila;
  assign lane_en = r.en;
  assign mode_unsupported = r.bad;

  // Next-state logic for divider, generators and output stage
  always_comb begin
    logic tick;
    logic gen;
    logic start;
    logic bad;
    logic on;
    logic [2:0] li;
    logic [LFSR_W-1:0] ns;
    stpg_lanes_t w;
    stpg_lanes_t cgs;
    tick = 1'b0;
    gen = 1'b0;
    start = 1'b0;
    bad = 1'b0;
    on = 1'b0;
    li = '0;
    ns = '0;
    w = '0;
    cgs = '0;
    r_nxt = r;
    // Pin crossing; only the second stage is looked at
    r_nxt.sync = {r.sync[0], ~sync_req_n};
    tick = (r.div == SLOT_DIV - 4'h1);
    r_nxt.div = tick ? '0 : r.div + 4'h1;
    if (r.push && f_in_ready) begin
      r_nxt.push = 1'b0;
    end
    // A full buffer stalls the generators, no slot is dropped
    gen = tick && (!r.push || f_in_ready);
    if (r.out_valid && out_ready) begin
      r_nxt.out_valid = 1'b0;
    end
    if (f_out_valid && f_pop) begin
      r_nxt.out_valid = 1'b1;
      r_nxt.out = f_out;
    end
    // Modes that exist only with 8b/10b are refused under 64b/66b
    bad = link_64b66b && (r.mode == STPG_K28_5 || r.mode == STPG_RILA
                          || r.mode == STPG_RPAT);
    r_nxt.bad = bad;
    // Per-lane slot contents; disabled high lanes stay at zero
    for (int l = 0; l < NUM_LANES; l++) begin
      li = 3'(l % LANES_PER_LINK);
      on = ({1'b0, li} < link_lanes_per_link);
      r_nxt.en[l] = on;
      ns = prbs_adv(r.lfsr[l], r.mode);
      cgs.data[l] = on ? CHAR_K28_5 : '0;
      cgs.k[l] = on;
      case (r.mode)
        STPG_PRBS7, STPG_PRBS9, STPG_PRBS15, STPG_PRBS23, STPG_PRBS31: begin
          w.data[l] = ns[OCT_W-1:0];
        end
        STPG_CLOCK: w.data[l] = r.clk_ph ? CLK_ZEROS : CLK_ONES;
        STPG_RAMP: w.data[l] = r.pos[OCT_W-1:0];
        STPG_SHORT: w.data[l] = short_oct(link_word_mode, li, r.oct, r.frm);
        STPG_D21_5: w.data[l] = CHAR_D21_5;
        STPG_K28_5: begin
          w.data[l] = CHAR_K28_5;
          w.k[l] = 1'b1;
        end
        STPG_RPAT: w.data[l] = RPAT_TBL[r.rpat];
        default: w.data[l] = '0;
      endcase
      if (!on) begin
        w.data[l] = '0;
        w.k[l] = 1'b0;
      end
      if (gen && r.st == GS_RUN) begin
        r_nxt.lfsr[l] = ns;
      end
    end
    // Raw modes skip scrambler and encoder downstream
    // Ramp stays cooked so the link layer still encodes and scrambles it
    w.raw = (r.mode >= STPG_PRBS7 && r.mode <= STPG_CLOCK);
    w.ila = (r.mode == STPG_RILA);
    // Selection change restarts every generator from its seed
    if (test_pattern_select != r.mode) begin
      r_nxt.mode = stpg_mode_t'(test_pattern_select);
      r_nxt.st = GS_IDLE;
      for (int l = 0; l < NUM_LANES; l++) begin
        r_nxt.lfsr[l] = lane_seed(4'(l));
      end
      r_nxt.clk_ph = 1'b0;
      r_nxt.pos = '0;
      r_nxt.oct = '0;
      r_nxt.frm = 1'b0;
      r_nxt.rpat = '0;
    end else begin
      case (r.st)
        GS_IDLE: begin
          if (r.mode != STPG_NORMAL && !bad) begin
            r_nxt.st = GS_WAIT;
          end
        end
        GS_WAIT: begin
          // Ramp under 8b/10b waits for the end of ILA
          if (r.mode == STPG_RAMP && !link_64b66b) begin
            start = ila_done;
          end else begin
            start = serdes_ready;
          end
          if (start) begin
            r_nxt.st = GS_RUN;
          end
        end
        GS_RUN: begin
          if (gen) begin
            if (r.mode == STPG_RILA && r.sync[1]) begin
              r_nxt.st = GS_CGS;
            end else begin
              r_nxt.push = 1'b1;
              r_nxt.pw = (r.mode == STPG_RILA) ? '0 : w;
              r_nxt.pw.ila = w.ila;
              r_nxt.clk_ph = ~r.clk_ph;
              // Octet count restarts at the multiframe boundary
              r_nxt.pos = (r.pos >= mf_octets - 11'h1) ? '0 : r.pos + 11'h1;
              r_nxt.rpat = (r.rpat == RPAT_LAST) ? '0 : r.rpat + 4'h1;
              if (r.oct == frame_last(link_word_mode)) begin
                r_nxt.oct = '0;
                r_nxt.frm = ~r.frm;
              end else begin
                r_nxt.oct = r.oct + 3'h1;
              end
            end
          end
        end
        GS_CGS: begin
          // K28.5 code groups while the receiver holds its request
          if (gen) begin
            r_nxt.push = 1'b1;
            r_nxt.pw = cgs;
            if (!r.sync[1]) begin
              r_nxt.st = GS_RUN;
            end
          end
        end
        default: r_nxt.st = GS_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end
endmodule

/* File: sim/stpg_top_sva.sv */
// Port checker for the test pattern generator
`timescale 1ns/1ps
module stpg_chk
  import stpg_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] test_pattern_select,
  input wire logic [3:0] link_lanes_per_link,
  input wire logic link_64b66b,
  input wire logic out_ready,
  input wire logic out_valid,
  input wire logic [NUM_LANES-1:0][OCT_W-1:0] lane_data,
  input wire logic [NUM_LANES-1:0] lane_k,
  input wire logic lane_raw,
  input wire logic ila_repeat,
  input wire logic [NUM_LANES-1:0] lane_en,
  input wire logic mode_unsupported
);
  logic [NUM_LANES-1:0] en_exp;
  logic dis_nz;
  logic k_bad;
  // Expected lane enables and per-lane content faults
  always_comb begin
    dis_nz = 1'b0;
    k_bad = 1'b0;
    for (int l = 0; l < NUM_LANES; l++) begin
      en_exp[l] = (l % LANES_PER_LINK) < int'(link_lanes_per_link);
      dis_nz |= !lane_en[l] && (lane_data[l] != 8'h00);
      k_bad |= lane_k[l] && (lane_data[l] != 8'hbc);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(lane_data) && $stable(lane_k)
    && $stable(lane_raw) && $stable(ila_repeat); endproperty
  a_hold: assert property (p_hold) else $error("word changed before it was taken");
  property p_en; !$past(sys_rst) |-> lane_en == $past(en_exp); endproperty
  a_en: assert property (p_en) else $error("lane enables wrong");
  property p_dis; out_valid |-> !dis_nz; endproperty
  a_dis: assert property (p_dis) else $error("disabled lane not zero");
  // Selection loads one edge, the refusal flag registers on the next
  property p_unsup; !$past(sys_rst) && link_64b66b && $past(link_64b66b) && test_pattern_select inside {4'ha, 4'hb, 4'hc}
    && $past(test_pattern_select) inside {4'ha, 4'hb, 4'hc} |=> mode_unsupported && !out_valid; endproperty
  a_unsup: assert property (p_unsup) else $error("coding-limited mode not refused");
  property p_raw; out_valid && lane_raw |-> lane_k == '0 && !ila_repeat; endproperty
  a_raw: assert property (p_raw) else $error("raw word carries control");
  property p_k; out_valid && !ila_repeat |-> !k_bad; endproperty
  a_k: assert property (p_k) else $error("control lane not K28.5");
  property p_ila; out_valid && ila_repeat |-> lane_data == '0 && !lane_raw; endproperty
  a_ila: assert property (p_ila) else $error("ila slot carries data");
  property p_rst; disable iff (1'b0) sys_rst |=> !out_valid && lane_en == '0 && !mode_unsupported; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_alt; out_valid && out_ready && test_pattern_select == STPG_CLOCK ##1 out_valid
    |-> lane_raw && lane_data[0] == ~$past(lane_data[0]); endproperty
  a_alt: assert property (p_alt) else $error("clock pattern did not alternate");
endmodule

bind stpg_top stpg_chk i_stpg_chk (.clk(clk), .sys_rst(sys_rst), .test_pattern_select(test_pattern_select),
  .link_lanes_per_link(link_lanes_per_link), .link_64b66b(link_64b66b), .out_ready(out_ready),
  .out_valid(out_valid), .lane_data(lane_data), .lane_k(lane_k), .lane_raw(lane_raw),
  .ila_repeat(ila_repeat), .lane_en(lane_en), .mode_unsupported(mode_unsupported));

/* File: sim/stpg_sink.sv */
// Link receiver stand-in: takes words and raises sync requests
`timescale 1ns/1ps
module stpg_sink (
  input wire logic clk,
  input wire logic rnd,
  input wire logic slow,
  input wire logic hold,
  input wire logic want_sync,
  output logic out_ready,
  output logic sync_req_n
);
  initial begin
    out_ready = 1'b0;
    sync_req_n = 1'b1;
  end
  // Changes just after the rising edge; a slow sink stalls at random
  always @(posedge clk) begin
    out_ready <= !hold && (!slow || rnd);
    sync_req_n <= !want_sync;
  end
endmodule

/* File: sim/tb_serial_link_test_pattern_gen.sv */
// Self-checking bench for the test pattern generator
`timescale 1ns/1ps
module tb_serial_link_test_pattern_gen
  import stpg_pkg::*;
;
  localparam int WW = $bits(stpg_lanes_t);
  logic clk = 1'b0, sys_rst = 1'b1, link_64b66b = 1'b0, ila_done = 1'b0, serdes_ready = 1'b1;
  logic [3:0] test_pattern_select = 4'h0, link_lanes_per_link = 4'h4;
  logic [1:0] link_word_mode = 2'h0;
  logic [10:0] mf_octets = 11'h003;
  logic rnd = 1'b0, slow = 1'b0, hold = 1'b0, want_sync = 1'b0;
  logic out_ready, sync_req_n, out_valid, lane_raw, ila_repeat, mode_unsupported;
  logic [NUM_LANES-1:0][OCT_W-1:0] lane_data;
  logic [NUM_LANES-1:0] lane_k, lane_en;
  logic [31:0] seed = 32'hee38cd8d;
  int fail_count = 0, compares = 0, cyc = 0;
  int ta[5] = '{6, 5, 14, 18, 28};
  int tb[5] = '{7, 9, 15, 23, 31};
  logic [7:0] rp[12] = '{8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f, 8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59};
  stpg_lanes_t q[$], cap[$];

  initial begin
    forever #50 clk = ~clk;
  end
  stpg_top i_stpg_top (.clk(clk), .sys_rst(sys_rst), .test_pattern_select(test_pattern_select),
    .link_word_mode(link_word_mode), .link_lanes_per_link(link_lanes_per_link), .link_64b66b(link_64b66b),
    .mf_octets(mf_octets), .ila_done(ila_done), .serdes_ready(serdes_ready), .sync_req_n(sync_req_n),
    .out_ready(out_ready), .out_valid(out_valid), .lane_data(lane_data), .lane_k(lane_k), .lane_raw(lane_raw),
    .ila_repeat(ila_repeat), .lane_en(lane_en), .mode_unsupported(mode_unsupported));
  stpg_sink i_stpg_sink (.clk(clk), .rnd(rnd), .slow(slow), .hold(hold), .want_sync(want_sync),
    .out_ready(out_ready), .sync_req_n(sync_req_n));

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Random stall bit for the sink
  always @(negedge clk) begin
    seed <= xs(seed);
    rnd <= seed[0];
  end
  // Hang guard, well above the whole run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic check(input logic [WW-1:0] seen, input logic [WW-1:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Each taken word is logged; while notes are queued it is matched against the oldest
  always @(posedge clk) begin
    if (!sys_rst && out_valid && out_ready) begin
      cap.push_back({lane_raw, ila_repeat, lane_k, lane_data});
      if (q.size() > 0) check(cap[$], q.pop_front());
    end
  end
  // Word with one octet per enabled lane, disabled lanes zero
  function automatic stpg_lanes_t wd(logic raw, logic k, logic [7:0] o, logic [7:0] inc);
    wd = '0;
    wd.raw = raw;
    for (int l = 0; l < NUM_LANES; l++) begin
      if ((l % 8) < int'(link_lanes_per_link)) begin
        wd.k[l] = k;
        wd.data[l] = o + inc * 8'(l % 8);
      end
    end
  endfunction
  function automatic logic [3:0] nib(int m, int k, int n);
    if (m != 1) return 4'((4 * k + n) % 16);
    if (n == 15) return 4'h0;
    return n % 3 == 0 ? 4'(15 - k) : n % 3 == 1 ? 4'(k) : 4'(n / 3 + 1);
  endfunction
  task automatic run(input logic [3:0] m, input logic [1:0] wm, input logic [3:0] lpl, input logic b64,
                     input logic [10:0] mf);
    @(negedge clk);
    sys_rst = 1'b1;
    test_pattern_select = 4'h0;
    link_word_mode = wm;
    link_lanes_per_link = lpl;
    link_64b66b = b64;
    mf_octets = mf;
    q.delete();
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    test_pattern_select = m;
    cap.delete();
  endtask
  task automatic drain(input string name);
    int n;
    n = 0;
    while (q.size() > 0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    check(WW'(q.size()), WW'(0));
    $display("test %s done, failures %0d", name, fail_count);
  endtask
  task automatic getw(input int n);
    int t;
    t = 0;
    while (cap.size() < n && t < 2000) begin
      @(negedge clk);
      t++;
    end
    check(WW'(cap.size() >= n), WW'(1));
  endtask
  task automatic test_done();
    $display("compares %0d, fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    stpg_lanes_t w;
    logic [63:0] y, y0, yp;
    int lpl;
    repeat (8) @(negedge clk);
    check(WW'({out_valid, lane_en}), WW'(0));
    // Clock pattern with the sink stalled: buffer fills, nothing lost
    hold = 1'b1;
    run(STPG_CLOCK, STPG_W8, 4'h4, 1'b0, 11'h003);
    for (int i = 0; i < 8; i++) q.push_back(wd(1'b1, 1'b0, i[0] ? 8'h00 : 8'hff, 8'h00));
    repeat (30) @(negedge clk);
    check(WW'(out_valid), WW'(1));
    hold = 1'b0;
    drain("clock");
    slow = 1'b1;
    for (int b = 0; b < 2; b++) begin
      lpl = 1 + seed % 8;
      run(STPG_D21_5, STPG_W8, 4'(lpl), b[0], 11'h003);
      for (int i = 0; i < 5; i++) q.push_back(wd(1'b0, 1'b0, 8'hb5, 8'h00));
      drain("d21_5");
    end
    run(STPG_K28_5, STPG_W8, 4'h8, 1'b0, 11'h003);
    for (int i = 0; i < 5; i++) q.push_back(wd(1'b0, 1'b1, 8'hbc, 8'h00));
    drain("k28_5");
    run(STPG_RPAT, STPG_W8, 4'h2, 1'b0, 11'h003);
    for (int i = 0; i < 26; i++) q.push_back(wd(1'b0, 1'b0, rp[i % 12], 8'h00));
    drain("rpat");
    // Short transport frames for every word mode, sixteen slots each
    for (int m = 0; m < 4; m++) begin
      run(STPG_SHORT, 2'(m), m < 2 ? 4'h8 : m == 2 ? 4'h6 : 4'h3, 1'b0, 11'h003);
      for (int o = 0; o < 16; o++) begin
        w = wd(1'b0, 1'b0, 8'h00, 8'h00);
        for (int l = 0; l < NUM_LANES; l++) begin
          lpl = 2 * (o % (m == 1 ? 8 : 2));
          if ((l % 8) < int'(link_lanes_per_link)) w.data[l] = m == 0 ? (o[0] ? 8'(255 - l % 8) : 8'(l % 8)) :
            {nib(m, l % 8, lpl), nib(m, l % 8, lpl + 1)};
        end
        q.push_back(w);
      end
      drain("short");
    end
    // Ramp waits for serializers (64b/66b) or the end of ILA (8b/10b)
    serdes_ready = 1'b0;
    run(STPG_RAMP, STPG_W8, 4'h4, 1'b1, 11'h003);
    for (int i = 0; i < 7; i++) q.push_back(wd(1'b0, 1'b0, 8'(i % 3), 8'h00));
    repeat (20) @(negedge clk);
    check(WW'(cap.size()), WW'(0));
    serdes_ready = 1'b1;
    drain("ramp");
    run(STPG_RAMP, STPG_W8, 4'h8, 1'b0, 11'h104);
    for (int i = 0; i < 262; i++) q.push_back(wd(1'b0, 1'b0, 8'(i % 260), 8'h00));
    repeat (20) @(negedge clk);
    check(WW'(cap.size()), WW'(0));
    ila_done = 1'b1;
    drain("ramp_wrap");
    // PRBS: recurrence checked on the received bits, any start phase
    slow = 1'b0;
    for (int m = 1; m < 6; m++) begin
      run(4'(m), STPG_W8, 4'h8, 1'b0, 11'h003);
      getw(8);
      // Long generators open with zero octets on every lane, so whole streams are compared
      for (int l = 0; l < NUM_LANES; l++) begin
        for (int j = 0; j < 8; j++) y = {y[55:0], cap[j].data[l]};
        for (int n = tb[m-1]; n < 64; n++) check(WW'(y[63-n]), WW'(y[63-n+ta[m-1]] ^ y[63-n+tb[m-1]]));
        if (l > 0) check(WW'({y == y0, y == yp}), WW'(0));
        if (l == 0) y0 = y;
        yp = y;
      end
      check(WW'(cap[0].raw), WW'(1));
      $display("test prbs %0d done, failures %0d", m, fail_count);
    end
    run(STPG_RILA, STPG_W8, 4'h4, 1'b0, 11'h003);
    want_sync = 1'b1;
    repeat (30) @(negedge clk);
    cap.delete();
    getw(2);
    check(cap[1], wd(1'b0, 1'b1, 8'hbc, 8'h00));
    want_sync = 1'b0;
    repeat (30) @(negedge clk);
    cap.delete();
    getw(2);
    check(WW'({cap[1].ila, cap[1].data}), WW'({1'b1, 128'h0}));
    for (int m = 10; m < 13; m++) begin
      run(4'(m), STPG_W8, 4'h4, 1'b1, 11'h003);
      repeat (20) @(negedge clk);
      check(WW'({mode_unsupported, out_valid}), WW'(2));
    end
    $display("test misc done, failures %0d", fail_count);
    test_done();
  end
endmodule
